/* File: hdl/i2c_tx_defs.svh */
// Register offsets, field positions and reset values of the transmitter.
`ifndef I2C_TX_DEFS_SVH
`define I2C_TX_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADDR_TX_BUF 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_PERIOD 8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_START 0
`define CTRL_RESTART 1
`define CTRL_STOP 2
`define CTRL_ACK 7
`define STAT_FULL 0
`define STAT_BUSY 1
`define IRQ_PORT 0
`define IRQ_WRITE_COLLISION_FLAG 1
`define IRQ_BCOL 2

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define PERIOD_RESET 8'h18
`define IRQ_MASK_RESET 3'h0
`define BIT_ACK 4'h8
`define BIT_LAST 4'h7

`endif

/* File: hdl/i2c_tx_pkg.sv */
// Types shared by the transmitter modules.
package i2c_tx_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START_A,
        ST_START_B,
        ST_HOLD,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_STOP_A,
        ST_STOP_B,
        ST_STOP_C,
        ST_RST_A,
        ST_RST_B
    } phase_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } baud_type;

    typedef struct packed {
        phase_type phase;
        logic [7:0] tx_buffer_reg;
        logic [7:0] byte_shift_register;
        logic [3:0] bit_cnt;
        logic fresh;
        logic buffer_full_flag;
        logic ack_status_bit;
        logic start_request_bit;
        logic restart_request_bit;
        logic stop_request_bit;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [7:0] period;
        logic [7:0] rdata;
        logic irq;
        logic sda_o;
        logic sda_oe;
        logic scl_o;
        logic scl_oe;
    } core_type;

endpackage

/* File: hdl/bit_phase_timer.sv */
// Baud generator that ticks once per bit phase period.
`timescale 1ns/1ns
`include "i2c_tx_defs.svh"

module bit_phase_timer
    import i2c_tx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic [7:0] period,
    output logic tick
);

    baud_type q_r;
    baud_type q_nxt;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // While stopped the counter is reloaded, so the first tick after a
    // restart comes a full period plus one cycle later.
    always_comb begin
        q_nxt = q_r;
        q_nxt.tick = 1'b0;
        if (!run) begin
            q_nxt.cnt = period;
        end else if (q_r.cnt == 8'h00) begin
            q_nxt.cnt = period;
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.cnt = q_r.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_r <= '{cnt: `PERIOD_RESET, tick: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tick = q_r.tick;

endmodule

/* File: hdl/i2c_master_transmit.sv */
// Transmit path of a two-wire bus master with its register port.
`timescale 1ns/1ns
`include "i2c_tx_defs.svh"

// What this block does
// - Buffer write between operations, no collision pending, sets full flag, starts transmission
// - Bit driven after SCL falls, low one period
// - SCL released one period, SDA held stable
// - Eighth falling edge clears full, releases SDA
// - Ninth clock samples SDA into ack status
// - After ninth clock: irq, timer stops, SCL low
// - Address phase sends seven bits plus direction
// - Write during shifting sets collision, is discarded
// - Collision flag sticks until software clears it
// - Start request makes Start, then irq flag
// - Start hold time elapses before next operation
// - Stop or Restart request, then irq flag
// - Start is SDA falling while SCL high
// - Stop is SDA rising after SCL high time
// - SDA low before driving Start reports collision
module i2c_master_transmit
    import i2c_tx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);

    core_type q_r;
    core_type q_nxt;
    logic tick;
    logic run;
    logic buf_wr;
    logic accept;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True while a condition or a byte is on the bus and the timer runs.
    function automatic logic bus_busy(input phase_type p);
        bus_busy = (p != ST_IDLE) && (p != ST_HOLD);
    endfunction

    assign run = bus_busy(q_r.phase);

    bit_phase_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(run),
        .period(q_r.period),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        irq_set = 3'h0;
        irq_clr = 3'h0;
        buf_wr = wr && (addr == `ADDR_TX_BUF);
        // A byte is only taken while the bus is held between operations
        // and no collision is pending.
        accept = buf_wr && (q_r.phase == ST_HOLD)
            && !q_r.irq_stat[`IRQ_WRITE_COLLISION_FLAG];
        if (buf_wr && !accept) begin
            irq_set[`IRQ_WRITE_COLLISION_FLAG] = 1'b1;
        end
        q_nxt.sda_o = 1'b0;
        q_nxt.scl_o = 1'b0;

        // Register writes other than the transmit buffer.
        if (wr) begin
            if (addr == `ADDR_CTRL) begin
                if (q_r.phase == ST_IDLE) begin
                    q_nxt.start_request_bit = wdata[`CTRL_START];
                end else if (q_r.phase == ST_HOLD) begin
                    q_nxt.restart_request_bit = wdata[`CTRL_RESTART];
                    q_nxt.stop_request_bit = wdata[`CTRL_STOP];
                end
            end else if (addr == `ADDR_IRQ_STAT) begin
                irq_clr = wdata[2:0];
            end else if (addr == `ADDR_IRQ_MASK) begin
                q_nxt.irq_mask = wdata[2:0];
            end else if (addr == `ADDR_PERIOD) begin
                q_nxt.period = wdata;
            end
        end

        case (q_r.phase)
            ST_IDLE: begin
                q_nxt.sda_oe = 1'b0;
                q_nxt.scl_oe = 1'b0;
                if (q_r.start_request_bit) begin
                    if (!sda_i) begin
                        irq_set[`IRQ_BCOL] = 1'b1;
                        q_nxt.start_request_bit = 1'b0;
                    end else begin
                        q_nxt.sda_oe = 1'b1;
                        q_nxt.phase = ST_START_A;
                    end
                end
            end
            ST_START_A: begin
                // SDA low with SCL high for one period is the hold time.
                if (tick) begin
                    q_nxt.scl_oe = 1'b1;
                    q_nxt.phase = ST_START_B;
                end
            end
            ST_START_B: begin
                if (tick) begin
                    irq_set[`IRQ_PORT] = 1'b1;
                    q_nxt.start_request_bit = 1'b0;
                    q_nxt.restart_request_bit = 1'b0;
                    q_nxt.phase = ST_HOLD;
                end
            end
            ST_HOLD: begin
                q_nxt.scl_oe = 1'b1;
                if (accept) begin
                    q_nxt.tx_buffer_reg = wdata;
                    q_nxt.byte_shift_register = wdata;
                    q_nxt.buffer_full_flag = 1'b1;
                    q_nxt.bit_cnt = 4'h0;
                    q_nxt.fresh = 1'b1;
                    q_nxt.phase = ST_BIT_LOW;
                end else if (q_r.stop_request_bit) begin
                    q_nxt.sda_oe = 1'b1;
                    q_nxt.phase = ST_STOP_A;
                end else if (q_r.restart_request_bit) begin
                    q_nxt.sda_oe = 1'b0;
                    q_nxt.phase = ST_RST_A;
                end
            end
            ST_BIT_LOW: begin
                q_nxt.scl_oe = 1'b1;
                // SDA moves one cycle after SCL falls, giving hold time.
                if (q_r.fresh) begin
                    q_nxt.fresh = 1'b0;
                    if (q_r.bit_cnt == `BIT_ACK) begin
                        q_nxt.sda_oe = 1'b0;
                    end else begin
                        // MSB first: address bits then direction.
                        q_nxt.sda_oe = !q_r.byte_shift_register[7];
                    end
                end
                if (tick) begin
                    q_nxt.scl_oe = 1'b0;
                    q_nxt.phase = ST_BIT_HIGH;
                end
            end
            ST_BIT_HIGH: begin
                if (tick) begin
                    q_nxt.scl_oe = 1'b1;
                    q_nxt.fresh = 1'b1;
                    if (q_r.bit_cnt == `BIT_ACK) begin
                        q_nxt.ack_status_bit = sda_i;
                        irq_set[`IRQ_PORT] = 1'b1;
                        q_nxt.phase = ST_HOLD;
                    end else begin
                        q_nxt.byte_shift_register =
                            {q_r.byte_shift_register[6:0], 1'b0};
                        q_nxt.bit_cnt = q_r.bit_cnt + 4'h1;
                        if (q_r.bit_cnt == `BIT_LAST) begin
                            q_nxt.buffer_full_flag = 1'b0;
                        end
                        q_nxt.phase = ST_BIT_LOW;
                    end
                end
            end
            ST_STOP_A: begin
                // One SCL low time with SDA low precedes the Stop.
                if (tick) begin
                    q_nxt.scl_oe = 1'b0;
                    q_nxt.phase = ST_STOP_B;
                end
            end
            ST_STOP_B: begin
                if (tick) begin
                    q_nxt.sda_oe = 1'b0;
                    q_nxt.phase = ST_STOP_C;
                end
            end
            ST_STOP_C: begin
                if (tick) begin
                    irq_set[`IRQ_PORT] = 1'b1;
                    q_nxt.stop_request_bit = 1'b0;
                    q_nxt.phase = ST_IDLE;
                end
            end
            ST_RST_A: begin
                if (tick) begin
                    q_nxt.scl_oe = 1'b0;
                    q_nxt.phase = ST_RST_B;
                end
            end
            ST_RST_B: begin
                if (tick) begin
                    q_nxt.sda_oe = 1'b1;
                    q_nxt.phase = ST_START_A;
                end
            end
            default: begin
                q_nxt.phase = ST_IDLE;
            end
        endcase

        // A new event wins over a clear in the same cycle.
        q_nxt.irq_stat = (q_r.irq_stat & ~irq_clr) | irq_set;
        q_nxt.irq = |(q_nxt.irq_stat & q_nxt.irq_mask);

        q_nxt.rdata = 8'h00;
        if (rd) begin
            if (addr == `ADDR_TX_BUF) begin
                q_nxt.rdata = q_r.tx_buffer_reg;
            end else if (addr == `ADDR_CTRL) begin
                q_nxt.rdata = {q_r.ack_status_bit, 4'h0,
                    q_r.stop_request_bit, q_r.restart_request_bit,
                    q_r.start_request_bit};
            end else if (addr == `ADDR_STATUS) begin
                q_nxt.rdata = {6'h00, run, q_r.buffer_full_flag};
            end else if (addr == `ADDR_IRQ_STAT) begin
                q_nxt.rdata = {5'h00, q_r.irq_stat};
            end else if (addr == `ADDR_IRQ_MASK) begin
                q_nxt.rdata = {5'h00, q_r.irq_mask};
            end else if (addr == `ADDR_PERIOD) begin
                q_nxt.rdata = q_r.period;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_r <= '0;
            q_r.phase <= ST_IDLE;
            q_r.period <= `PERIOD_RESET;
            q_r.irq_mask <= `IRQ_MASK_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign rdata = q_r.rdata;
    assign irq = q_r.irq;
    assign sda_o = q_r.sda_o;
    assign sda_oe = q_r.sda_oe;
    assign scl_o = q_r.scl_o;
    assign scl_oe = q_r.scl_oe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_buf_accept: assert property (
        accept |=> q_r.buffer_full_flag && q_r.phase == ST_BIT_LOW
            ##1 run)
        else $error("accepted byte did not start a transfer");

    a_write_collision_flag_busy: assert property (
        buf_wr && run |=> q_r.irq_stat[`IRQ_WRITE_COLLISION_FLAG]
            && q_r.tx_buffer_reg == $past(q_r.tx_buffer_reg))
        else $error("busy write was not refused");

    a_write_collision_flag_sticky: assert property (
        q_r.irq_stat[`IRQ_WRITE_COLLISION_FLAG] && !(wr && addr == `ADDR_IRQ_STAT
            && wdata[`IRQ_WRITE_COLLISION_FLAG]) |=> q_r.irq_stat[`IRQ_WRITE_COLLISION_FLAG])
        else $error("collision flag dropped without a clear");

    a_sda_on_low: assert property (
        $changed(sda_oe) && q_r.phase inside {ST_BIT_LOW, ST_BIT_HIGH}
            |-> scl_oe && $past(scl_oe))
        else $error("data changed while SCL was released");

    a_ack_release: assert property (
        q_r.phase == ST_BIT_HIGH && q_r.bit_cnt == `BIT_ACK
            |-> !sda_oe && !q_r.buffer_full_flag)
        else $error("SDA held during acknowledge clock");

    a_ack_sample: assert property (
        q_r.phase == ST_BIT_HIGH && q_r.bit_cnt == `BIT_ACK && tick
            |=> q_r.ack_status_bit == $past(sda_i)
            && q_r.irq_stat[`IRQ_PORT] && q_r.phase == ST_HOLD)
        else $error("acknowledge not stored or flag not raised");

    a_hold_scl_low: assert property (
        q_r.phase == ST_HOLD && $past(q_r.phase) == ST_HOLD
            |-> scl_oe && !run)
        else $error("SCL not held low while waiting");

    a_start_edge: assert property (
        $rose(sda_oe) && !scl_oe |-> q_r.phase == ST_START_A)
        else $error("SDA fell with SCL high outside a Start");

    a_stop_edge: assert property (
        $fell(sda_oe) && !scl_oe |-> q_r.phase == ST_STOP_C
            && $past(q_r.phase, 2) != ST_START_B)
        else $error("SDA rose with SCL high outside a Stop");

    a_start_bcol: assert property (
        q_r.phase == ST_IDLE && q_r.start_request_bit && !sda_i
            |=> q_r.irq_stat[`IRQ_BCOL] && !sda_oe)
        else $error("bus collision on Start not reported");

    a_start_irq: assert property (
        q_r.phase == ST_START_B && tick |=> q_r.irq_stat[`IRQ_PORT]
            && !q_r.start_request_bit)
        else $error("Start completion not flagged");

    a_open_drain: assert property (
        !sda_o && !scl_o)
        else $error("a line was driven high");

endmodule

/* File: dv/i2c_slave_model.sv */
// Behavioural two-wire slave that receives bytes and acknowledges them.
`timescale 1ns/1ns

module i2c_slave_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sda,
    input wire logic scl,
    input wire logic ack_en,
    output logic sda_low,
    output logic [7:0] rx_byte,
    output int start_cnt,
    output int stop_cnt
);
    logic sda_q;
    logic scl_q;
    logic [3:0] bit_n;
    logic [7:0] shift;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sda_q <= 1'b1;
            scl_q <= 1'b1;
            bit_n <= 4'hf;
            shift <= 8'h00;
            rx_byte <= 8'h00;
            sda_low <= 1'b0;
            start_cnt <= 0;
            stop_cnt <= 0;
        end else begin
            sda_q <= sda;
            scl_q <= scl;
            if (scl && scl_q && sda_q && !sda) begin
                start_cnt <= start_cnt + 1;
                bit_n <= 4'h0;
            end else if (scl && scl_q && !sda_q && sda) begin
                stop_cnt <= stop_cnt + 1;
                bit_n <= 4'hf;
            end else if (scl && !scl_q && bit_n < 4'h8) begin
                shift <= {shift[6:0], sda};
                bit_n <= bit_n + 4'h1;
            end else if (!scl && scl_q && bit_n == 4'h8) begin
                rx_byte <= shift;
                sda_low <= ack_en;
                bit_n <= 4'h9;
            end else if (!scl && scl_q && bit_n == 4'h9) begin
                sda_low <= 1'b0;
                bit_n <= 4'h0;
            end
        end
    end
endmodule

/* File: dv/tb_i2c_master_transmit.sv */
// Self-checking bench for the two-wire transmit block.
`timescale 1ns/1ns
`include "i2c_tx_defs.svh"

module tb_i2c_master_transmit;
    logic clk_sys;
    logic rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic irq;
    logic sda_o;
    logic sda_oe;
    logic scl_o;
    logic scl_oe;
    logic sda;
    logic scl;
    logic slv_low;
    logic hold_low;
    logic ack_en;
    logic [7:0] slv_byte;
    int start_cnt;
    int stop_cnt;
    int fail_count;
    int checks;
    int cyc;
    logic [7:0] d;

    // ------------------------------------------------------------------
    // Wires with pull-ups
    // ------------------------------------------------------------------
    assign sda = !(sda_oe || slv_low || hold_low);
    assign scl = !scl_oe;

    i2c_master_transmit u_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .irq(irq),
        .sda_i(sda),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .scl_i(scl),
        .scl_o(scl_o),
        .scl_oe(scl_oe)
    );

    i2c_slave_model u_slave (
        .clk_sys(clk_sys),
        .rst(rst),
        .sda(sda),
        .scl(scl),
        .ack_en(ack_en),
        .sda_low(slv_low),
        .rx_byte(slv_byte),
        .start_cnt(start_cnt),
        .stop_cnt(stop_cnt)
    );

    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic results;
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        d = rdata;
    endtask

    task automatic wait_irq;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        chk("irq", 8'h01, {7'h00, irq});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd_reg(`ADDR_PERIOD);
        chk("period", `PERIOD_RESET, d);
        @(negedge clk_sys);
        chk("rdata idle", 8'h00, rdata);
        rd_reg(`ADDR_IRQ_MASK);
        chk("mask", 8'h00, d);
        rd_reg(8'h20);
        chk("unmapped", 8'h00, d);
        wr_reg(`ADDR_PERIOD, 8'h01);
        rd_reg(`ADDR_PERIOD);
        chk("period", 8'h01, d);
        wr_reg(`ADDR_IRQ_MASK, 8'h01);
    endtask

    task automatic t_start;
        int k;
        k = 0;
        wr_reg(`ADDR_CTRL, 8'h01);
        while (sda_oe !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        k = 0;
        // SDA low with SCL high lasts one bit phase plus the timer reload.
        while (scl_oe !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        chk("start hold", 8'h03, 8'(k));
        wait_irq();
        chk("start seen", 8'h01, 8'(start_cnt));
        chk("sda held", 8'h01, {7'h00, sda_oe});
        chk("drive level", 8'h00, {6'h00, sda_o, scl_o});
        rd_reg(`ADDR_CTRL);
        chk("start bit", 8'h00, d & 8'h07);
        wr_reg(`ADDR_IRQ_STAT, 8'h01);
        rd_reg(`ADDR_IRQ_STAT);
        chk("irq clear", 8'h00, d);
    endtask

    task automatic t_byte(input logic [7:0] b, input logic ack,
                          input logic hit);
        ack_en <= ack;
        wr_reg(`ADDR_TX_BUF, b);
        rd_reg(`ADDR_STATUS);
        chk("full busy", 8'h03, d & 8'h03);
        if (hit) begin
            wr_reg(`ADDR_TX_BUF, ~b);
            rd_reg(`ADDR_IRQ_STAT);
            chk("write_collision_flag", 8'h02, d);
            chk("masked irq", 8'h00, {7'h00, irq});
            rd_reg(`ADDR_TX_BUF);
            chk("buffer kept", b, d);
        end
        wait_irq();
        chk("slave byte", b, slv_byte);
        rd_reg(`ADDR_CTRL);
        chk("ack status", {~ack, 7'h00}, d & 8'h80);
        rd_reg(`ADDR_STATUS);
        chk("full clear", 8'h00, d & 8'h01);
        repeat (10) @(negedge clk_sys);
        chk("scl low", 8'h01, {7'h00, scl_oe});
        chk("sda free", 8'h00, {7'h00, sda_oe});
        rd_reg(`ADDR_IRQ_STAT);
        chk("irq stat", {6'h00, hit, 1'b1}, d);
        wr_reg(`ADDR_IRQ_STAT, 8'h03);
        @(negedge clk_sys);
        chk("irq low", 8'h00, {7'h00, irq});
    endtask

    task automatic t_restart;
        wr_reg(`ADDR_CTRL, 8'h02);
        wait_irq();
        chk("restart seen", 8'h02, 8'(start_cnt));
        chk("sda held", 8'h01, {7'h00, sda_oe});
        rd_reg(`ADDR_CTRL);
        chk("restart bit", 8'h00, d & 8'h07);
        wr_reg(`ADDR_IRQ_STAT, 8'h01);
    endtask

    task automatic t_stop;
        wr_reg(`ADDR_CTRL, 8'h04);
        wait_irq();
        chk("stop seen", 8'h01, 8'(stop_cnt));
        chk("lines free", 8'h00, {6'h00, scl_oe, sda_oe});
        wr_reg(`ADDR_IRQ_STAT, 8'h01);
    endtask

    task automatic t_bus_col;
        hold_low <= 1'b1;
        wr_reg(`ADDR_CTRL, 8'h01);
        repeat (4) @(negedge clk_sys);
        chk("no drive", 8'h00, {7'h00, sda_oe});
        rd_reg(`ADDR_IRQ_STAT);
        chk("bus col", 8'h04, d & 8'h04);
        rd_reg(`ADDR_CTRL);
        chk("start drop", 8'h00, d & 8'h01);
        hold_low <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        hold_low = 1'b0;
        ack_en = 1'b1;
        fail_count = 0;
        checks = 0;
        cyc = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_start();
        t_byte(8'ha4, 1'b1, 1'b1);
        t_byte(8'h5b, 1'b0, 1'b0);
        t_byte(8'h01, 1'b1, 1'b0);
        t_restart();
        t_stop();
        t_bus_col();
        results();
    end
endmodule
